// *** verification/bridge_monitor.sv ***
`timescale 1ns/1ns
module bridge_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // local link signals
  input wire logic local_strobe,
  input wire logic local_write,
  input wire logic [19:0] local_addr,
  input wire logic bridge_data_oe,
  input wire logic main_data_oe,
  input wire logic local_ack,
  input wire logic local_reset
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // handshake shape: ack two cycles after strobe, strobe held until the ack
  a_ack_two_late: assert property ($rose(local_strobe) |-> ##2 local_ack)
    else $error("local ack not two cycles after strobe");
  a_strobe_held: assert property (local_strobe && !local_ack |=> local_strobe)
    else $error("strobe dropped before ack");
  a_strobe_ends: assert property (local_ack |=> !local_strobe && !local_ack)
    else $error("strobe or ack held after ack");
  a_ack_in_cycle: assert property (local_ack |-> local_strobe)
    else $error("ack outside a strobe cycle");

  // data ownership of the shared bus
  a_read_driven: assert property (local_ack && !local_write |-> main_data_oe)
    else $error("read acked without data driven");
  a_write_driven: assert property (local_strobe && local_write |-> bridge_data_oe)
    else $error("write strobe without data driven");
  a_main_release: assert property (main_data_oe && !local_strobe |=> !main_data_oe)
    else $error("main end kept driving after strobe");
  a_no_contention: assert property (!(bridge_data_oe && main_data_oe))
    else $error("both ends drive the data bus");

  // a cycle keeps its address and direction; reset held after power-on
  a_addr_steady: assert property (
    local_strobe && $past(local_strobe) |-> $stable(local_addr) && $stable(local_write))
    else $error("address or direction moved in a cycle");
  a_power_on_reset: assert property ($fell(rst_i) |-> local_reset [*8])
    else $error("main reset not held after power-on");

  c_read_ack: cover property (local_ack && !local_write);
  c_write_ack: cover property (local_ack && local_write);
  c_reset_end: cover property ($fell(local_reset));
endmodule

// *** verification/vme_slave_local_bridge_tb.sv ***
`timescale 1ns/1ns
module vme_slave_local_bridge_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] ga_i = 5'h03;
  logic [4:0] addr_ga = 5'h03;
  logic [31:0] vme_addr_i = 32'h00000000;
  logic [5:0] vme_am_i = 6'h09;
  logic vme_as_n_i = 1'b1;
  logic [1:0] vme_ds_n_i = 2'h3;
  logic vme_write_n_i = 1'b1;
  logic [31:0] vme_data_i = 32'h00000000;
  logic [31:0] vme_data_o, user_wdata_o, user_rdata_i;
  logic vme_data_oe_o, vme_dtack_n_o, vme_dtack_oe_o, user_we_o, user_re_o, user_reset_o;
  logic [23:0] flash_addr_o;
  logic [15:0] flash_data_i, flash_data_o;
  logic flash_data_oe_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_rst_n_o;
  logic main_prog_n_o, cfg_run_o, cfg_image_o;
  logic cfg_done_i = 1'b0;
  logic [19:0] user_addr_o;
  logic [31:0] regs [0:15];
  logic stb_q = 1'b0;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int strobes = 0;
  int rcnt = 0, rlen = 0, fcnt = 0, flen = 0, pcnt = 0, plen = 0;

  local_link_if link();
  vme_slave_local_bridge vme_slave_local_bridge_inst (.clk_i, .rst_i, .ga_i, .vme_addr_i,
    .vme_am_i, .vme_as_n_i, .vme_ds_n_i, .vme_write_n_i, .vme_data_i, .vme_data_o,
    .vme_data_oe_o, .vme_dtack_n_o, .vme_dtack_oe_o, .link(link.bridge), .flash_addr_o,
    .flash_data_i, .flash_data_o, .flash_data_oe_o, .flash_ce_n_o, .flash_oe_n_o,
    .flash_we_n_o, .flash_rst_n_o, .main_prog_n_o, .cfg_run_o, .cfg_image_o, .cfg_done_i);
  main_fpga_end main_fpga_end_inst (.clk_i, .rst_i, .link(link.main_end), .user_addr_o,
    .user_wdata_o, .user_we_o, .user_re_o, .user_rdata_i, .user_reset_o);
  bridge_monitor bridge_monitor_inst (.clk_i, .rst_i, .local_strobe(link.local_strobe),
    .local_write(link.local_write), .local_addr(link.local_addr),
    .bridge_data_oe(link.bridge_data_oe), .main_data_oe(link.main_data_oe),
    .local_ack(link.local_ack), .local_reset(link.local_reset));

  always #10 clk_i = ~clk_i;

  // main logic registers and a flash whose word depends on its address
  assign user_rdata_i = regs[user_addr_o[5:2]];
  assign flash_data_i = flash_addr_o[15:0] ^ 16'hA5A5;
  always @(posedge clk_i) if (user_we_o) regs[user_addr_o[5:2]] <= user_wdata_o;

  // pulse lengths and strobe count, sampled mid-cycle to stay clear of the edge
  always @(negedge clk_i) begin
    rcnt = link.local_reset ? rcnt + 1 : 0;
    fcnt = !flash_rst_n_o ? fcnt + 1 : 0;
    pcnt = (!main_prog_n_o && !rst_i) ? pcnt + 1 : 0; // cycles in reset are not the pulse
    if (rcnt != 0) rlen = rcnt;
    if (fcnt != 0) flen = fcnt;
    if (pcnt != 0) plen = pcnt;
    if (link.local_strobe && !stb_q) strobes++;
    stb_q = link.local_strobe;
  end

  // hang guard, far beyond the under a thousand cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one vme beat; everything is held until dtack is seen or 40 cycles pass, then ds (and as if last) let go
  task automatic beat(input logic [19:0] off, input logic wr, input logic [31:0] wd,
      input logic blk, input logic last, output logic [31:0] rd, output logic ack);
    @(posedge clk_i);
    #1;
    ack = 1'b0;
    rd = 32'h00000000;
    vme_addr_i = {7'h00, addr_ga, off};
    vme_am_i = blk ? bridge_pkg::AM_A32_BLT_USR : 6'h09;
    vme_write_n_i = !wr;
    vme_data_i = wd;
    vme_as_n_i = 1'b0;
    vme_ds_n_i = 2'h0;
    for (int n = 0; n < 40 && !ack; n++) begin
      @(posedge clk_i);
      #1;
      if (vme_dtack_oe_o === 1'b1 && vme_dtack_n_o === 1'b0) begin
        ack = 1'b1;
        rd = vme_data_o;
        check(vme_data_oe_o, !wr);
      end
    end
    vme_ds_n_i = 2'h3;
    vme_data_i = ~wd;
    if (last) vme_as_n_i = 1'b1;
    for (int n = 0; n < 20 && vme_dtack_n_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    // strobes stay high long enough to pass the synchroniser, even without dtack
    repeat (2) @(posedge clk_i);
  endtask

  task automatic wr(input logic [19:0] off, input logic [31:0] wd, output logic ack);
    logic [31:0] d;
    beat(off, 1'b1, wd, 1'b0, 1'b1, d, ack);
  endtask

  task automatic rd(input logic [19:0] off, output logic [31:0] d);
    logic a;
    beat(off, 1'b0, 32'h00000000, 1'b0, 1'b1, d, a);
  endtask

  task automatic t_power_on;
    repeat (80) @(negedge clk_i);
    check(plen, bridge_pkg::PROG_CYC);
    check(cfg_run_o, 1'b1);
    check(cfg_image_o, 1'b0);
    cfg_done_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check(cfg_run_o, 1'b0);
  endtask

  task automatic t_main_regs;
    logic [31:0] d;
    logic a;
    int s;
    s = strobes;
    wr(20'h00010, 32'h12345678, a);
    check(a, 1'b1);
    rd(20'h00010, d);
    check(d, 32'h12345678);
    check(strobes - s, 2);
    for (int i = 0; i < 3; i++) beat(20'h00020 + 20'(4 * i), 1'b1, 32'hB0000000 + i, 1'b1,
      i == 2, d, a);
    for (int i = 0; i < 3; i++) begin
      beat(20'h00020 + 20'(4 * i), 1'b0, 32'h00000000, 1'b1, i == 2, d, a);
      check(d, 32'hB0000000 + i);
    end
  endtask

  task automatic t_windows;
    logic [31:0] d;
    logic a;
    int s;
    s = strobes;
    addr_ga = ga_i ^ 5'h10;
    wr(20'h00010, 32'hDEADBEEF, a);
    check(a, 1'b0);
    addr_ga = ga_i;
    check(strobes - s, 0);
    wr(20'h80FFC, 32'h0000F1F0, a);
    check(strobes - s, 1);
    wr(20'h81000, 32'h0000F1F1, a);
    rd(20'h00990, d);
    check(d, 32'h00000000);
    check(strobes - s, 1);
  endtask

  task automatic t_flash;
    logic [31:0] d;
    logic a;
    wr(bridge_pkg::OFF_FLASH_ADDR, 32'h00000100, a);
    for (int i = 0; i < 2; i++) begin
      rd(bridge_pkg::OFF_FLASH_AUTO, d);
      check(d, {16'h0102 + 16'(4 * i), 16'h0100 + 16'(4 * i)} ^ 32'hA5A5A5A5);
    end
    rd(bridge_pkg::OFF_FLASH_DATA, d);
    check(d, {16'h010A ^ 16'hA5A5, 16'h0108 ^ 16'hA5A5});
    rd(bridge_pkg::OFF_FLASH_ADDR, d);
    check(d, 32'h00000108);
    wr(bridge_pkg::OFF_FLASH_CMD, 32'h000000FF, a);
    rd(bridge_pkg::OFF_FLASH_CMD, d);
    check(d, 32'h00000000);
  endtask

  task automatic t_control;
    logic [31:0] d;
    logic a;
    rlen = 0;
    wr(bridge_pkg::OFF_CTRL, 32'h00000010, a);
    rd(bridge_pkg::OFF_CTRL, d);
    check(d, 32'h00000010);
    repeat (80) @(negedge clk_i);
    check(rlen, bridge_pkg::RST_CYC);
    rd(bridge_pkg::OFF_CTRL, d);
    check(d, 32'h00000000);
    wr(bridge_pkg::OFF_CTRL, 32'h00000020, a);
    repeat (80) @(negedge clk_i);
    check(flen, bridge_pkg::RST_CYC);
    cfg_done_i = 1'b0;
    plen = 0;
    wr(bridge_pkg::OFF_CTRL, 32'h00000101, a);
    repeat (60) @(negedge clk_i);
    check(plen, bridge_pkg::PROG_CYC);
    check(cfg_run_o, 1'b0);
    rd(bridge_pkg::OFF_CTRL, d);
    check(d, 32'h00000101);
    wr(bridge_pkg::OFF_CTRL, 32'h00000002, a);
    repeat (60) @(negedge clk_i);
    check(cfg_run_o, 1'b1);
    check(cfg_image_o, 1'b1);
    cfg_done_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check(cfg_run_o, 1'b0);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_power_on();
    t_main_regs();
    t_windows();
    t_flash();
    t_control();
    end_of_test();
  end
endmodule

// *** verilog/bridge_pkg.sv ***
package bridge_pkg;
  // address split: slot bits compared against geographical address pins
  localparam int ADDR_GA_HI = 24;
  localparam int ADDR_GA_LO = 20;
  localparam int OFF_W = 20;
  localparam int FLASH_ADDR_W = 24;
  localparam int CNT_W = 8;

  // board-space offsets
  localparam logic [19:0] OFF_MAIN_BASE = 20'h00000;
  localparam logic [19:0] OFF_OWN_BASE = 20'h00900;
  localparam logic [19:0] OFF_CTRL = 20'h00900;
  localparam logic [19:0] OFF_FLASH_ADDR = 20'h00980;
  localparam logic [19:0] OFF_FLASH_AUTO = 20'h00984;
  localparam logic [19:0] OFF_FLASH_DATA = 20'h00988;
  localparam logic [19:0] OFF_FLASH_CMD = 20'h0098C;
  localparam logic [19:0] OFF_OWN_TOP = 20'h00FFF;
  localparam logic [19:0] OFF_FIFO_BASE = 20'h01000;
  localparam logic [19:0] OFF_FIFO_TOP = 20'h80FFC;

  // control register bit positions
  localparam int CTRL_CFG_MAIN = 0;
  localparam int CTRL_CFG_DIAG = 1;
  localparam int CTRL_RST_MAIN = 4;
  localparam int CTRL_RST_FLASH = 5;
  localparam int CTRL_OVERRIDE = 8;
  localparam logic CTRL_OVERRIDE_RESET = 1'b0;

  // flash host port and vme block address steps
  localparam logic [23:0] FLASH_AUTO_STEP = 24'h000004;
  localparam logic [23:0] FLASH_HALF_STEP = 24'h000002;
  localparam logic [31:0] BLOCK_STEP = 32'h00000004;

  // block transfer address modifiers, A32 user and supervisor
  localparam logic [5:0] AM_A32_BLT_USR = 6'h0B;
  localparam logic [5:0] AM_A32_BLT_SUP = 6'h0F;

  // timing, 50 MHz clock
  localparam int CLK_MHZ = 50;
  localparam int RST_PULSE_NS = 1000;
  localparam int PROG_PULSE_NS = 500;
  localparam int FLASH_ACC_NS = 120;
  localparam logic [7:0] RST_CYC = 8'((RST_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] PROG_CYC = 8'((PROG_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] FLASH_ACC_CYC = 8'((FLASH_ACC_NS * CLK_MHZ + 999) / 1000);
endpackage

// *** verilog/local_link_if.sv ***
`timescale 1ns/1ns
interface local_link_if;
  logic local_strobe;
  logic local_write;
  logic [19:0] local_addr;
  logic [31:0] bridge_data;
  logic bridge_data_oe;
  logic [31:0] main_data;
  logic main_data_oe;
  logic [31:0] local_rdwr_bus;
  logic local_ack;
  logic local_reset;

  // shared data bus level worked out from the two enables
  assign local_rdwr_bus = bridge_data_oe ? bridge_data : (main_data_oe ? main_data : 32'h00000000);

  modport bridge (
    output local_strobe, local_write, local_addr, bridge_data, bridge_data_oe, local_reset,
    input local_rdwr_bus, local_ack
  );
  modport main_end (
    input local_strobe, local_write, local_addr, local_rdwr_bus, local_reset,
    output main_data, main_data_oe, local_ack
  );
endinterface

// *** verilog/main_fpga_end.sv ***
`timescale 1ns/1ns
module main_fpga_end (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // local link toward the bridge
  local_link_if.main_end link,
  // register port into the main logic
  output logic [19:0] user_addr_o,
  output logic [31:0] user_wdata_o,
  output logic user_we_o,
  output logic user_re_o,
  input wire logic [31:0] user_rdata_i,
  output logic user_reset_o
);
  typedef struct packed {
    logic seen;
    logic pend;
    logic ack;
    logic data_oe;
    logic [31:0] data;
    logic [19:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
    logic reset;
  } main_s;

  main_s r;
  main_s next_r;

  // one register op per strobe, acknowledged one cycle after it is issued
  always_comb begin
    next_r = r;
    next_r.we = 1'b0;
    next_r.re = 1'b0;
    next_r.ack = 1'b0;
    next_r.reset = link.local_reset;
    if (!link.local_strobe) begin
      next_r.seen = 1'b0;
      next_r.data_oe = 1'b0;
    end else if (!r.seen) begin
      next_r.seen = 1'b1;
      next_r.pend = 1'b1;
      next_r.addr = link.local_addr;
      next_r.wdata = link.local_rdwr_bus;
      next_r.we = link.local_write;
      next_r.re = !link.local_write;
    end
    if (r.pend) begin
      // write data already latched by user, read data captured here
      next_r.pend = 1'b0;
      next_r.ack = 1'b1; // one ack per strobe cycle
      next_r.data_oe = !link.local_write; // data on bus with the ack
      next_r.data = user_rdata_i;
    end
  end

  // all link signals change on the rising edge only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.local_ack = r.ack;
  assign link.main_data = r.data;
  assign link.main_data_oe = r.data_oe;
  assign user_addr_o = r.addr;
  assign user_wdata_o = r.wdata;
  assign user_we_o = r.we;
  assign user_re_o = r.re;
  assign user_reset_o = r.reset;
endmodule

// *** verilog/vme_slave_local_bridge.sv ***
`timescale 1ns/1ns
// Behaviour
// - resynchronise vme cycles before any local action
// - local link timed on rising clock edge
// - block and single transfers to all registers
// - bridge runs vme; main acks each strobe
// - block reads allowed from flash window
// - main acks reads with data driven
// - main acks writes after latching data
// - dtack only after cycle truly completes
// - select board by ga versus address 24:20
// - low offsets main, 0x900 up own
// - fifo window 0x01000 to 0x80FFC passed on
// - four flash host port locations
// - control bits 0,1,4,5 clear after their action
// - bits 0,1 reconfigure main or diagnostic
// - bit 4 pulses main fpga reset
// - bit 5 pulses flash reset
// - bit 8 withholds configuration data
// - reset and configure at power-on
// - auto-increment port adds four per access
// - a32/d32 single and block transfers
module vme_slave_local_bridge (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // vme slave pins, asynchronous
  input wire logic [4:0] ga_i,
  input wire logic [31:0] vme_addr_i,
  input wire logic [5:0] vme_am_i,
  input wire logic vme_as_n_i,
  input wire logic [1:0] vme_ds_n_i,
  input wire logic vme_write_n_i,
  input wire logic [31:0] vme_data_i,
  output logic [31:0] vme_data_o,
  output logic vme_data_oe_o,
  output logic vme_dtack_n_o,
  output logic vme_dtack_oe_o,
  // local link toward the main fpga
  local_link_if.bridge link,
  // configuration flash pins
  output logic [23:0] flash_addr_o,
  input wire logic [15:0] flash_data_i,
  output logic [15:0] flash_data_o,
  output logic flash_data_oe_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic flash_rst_n_o,
  // main fpga configuration
  output logic main_prog_n_o,
  output logic cfg_run_o,
  output logic cfg_image_o,
  input wire logic cfg_done_i
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DECODE = 6'h02,
    ST_LOCAL = 6'h04,
    ST_FLASH = 6'h08,
    ST_ACK = 6'h10,
    ST_SKIP = 6'h20
  } state_e;

  typedef enum logic [1:0] {
    RG_LOCAL = 2'h0,
    RG_OWN = 2'h1,
    RG_FLASH = 2'h2,
    RG_NONE = 2'h3
  } region_e;

  typedef struct packed {
    state_e state;
    logic in_cycle;
    logic block;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic dtack;
    logic data_oe;
    logic strobe;
    logic lwrite;
    logic [19:0] laddr;
    logic local_rdwr_bus_oe;
    logic [23:0] faddr;
    logic [23:0] fpin_addr;
    logic [15:0] fdata_out;
    logic fdata_oe;
    logic fce_n;
    logic foe_n;
    logic fwe_n;
    logic fhalf;
    logic fcmd;
    logic fauto;
    logic [7:0] fcnt;
    logic override;
    logic cfg_busy;
    logic cfg_image;
    logic [7:0] prog_cnt;
    logic prog_n;
    logic cfg_run;
    logic [7:0] main_rst_cnt;
    logic main_rst;
    logic [7:0] flash_rst_cnt;
    logic flash_rst_n;
  } bridge_s;

  bridge_s r;
  bridge_s next_r;
  logic [3:0] sync_lvl;
  logic as_act;
  logic ds_act;
  logic wr_act;
  logic [19:0] off;

  // maps a board offset to the part of the board that answers it
  function automatic region_e decode(input logic [19:0] o);
    if (o < bridge_pkg::OFF_OWN_BASE) begin
      decode = RG_LOCAL; // main fpga registers from offset zero
    end else if (o >= bridge_pkg::OFF_FIFO_BASE && o <= bridge_pkg::OFF_FIFO_TOP) begin
      decode = RG_LOCAL; // readout fifo window goes over the local link
    end else if (o >= bridge_pkg::OFF_FLASH_AUTO && o <= bridge_pkg::OFF_FLASH_CMD) begin
      decode = RG_FLASH;
    end else if (o <= bridge_pkg::OFF_OWN_TOP) begin
      decode = RG_OWN;
    end else begin
      decode = RG_NONE;
    end
  endfunction

  // strobes and write line only; address and data are stable once the strobes settle
  vme_sync #(.W(4)) strobe_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({vme_write_n_i, vme_ds_n_i, vme_as_n_i}),
    .sync_o(sync_lvl)
  );

  assign as_act = !sync_lvl[0];
  assign ds_act = !sync_lvl[1] && !sync_lvl[2]; // d32 needs both data strobes
  assign wr_act = !sync_lvl[3];
  assign off = r.addr[bridge_pkg::OFF_W-1:0];

  always_comb begin
    next_r = r;
    // pulse and configuration timers run beside the bus engine
    if (r.main_rst_cnt != 8'h00) begin
      next_r.main_rst_cnt = r.main_rst_cnt - 8'h01;
    end
    if (r.flash_rst_cnt != 8'h00) begin
      next_r.flash_rst_cnt = r.flash_rst_cnt - 8'h01;
    end
    if (r.cfg_busy) begin
      if (r.prog_cnt != 8'h00) begin
        next_r.prog_cnt = r.prog_cnt - 8'h01;
      end else if (cfg_done_i) begin
        next_r.cfg_busy = 1'b0;
      end
    end

    case (r.state)
      ST_IDLE: begin
        next_r.dtack = 1'b0;
        next_r.data_oe = 1'b0;
        if (!as_act) begin
          next_r.in_cycle = 1'b0;
          next_r.block = 1'b0;
        end else if (ds_act) begin
          if (!r.in_cycle) begin
            // address taken once per address phase, block beats step it
            next_r.addr = vme_addr_i;
            next_r.block = (vme_am_i == bridge_pkg::AM_A32_BLT_USR) ||
                           (vme_am_i == bridge_pkg::AM_A32_BLT_SUP);
          end
          next_r.in_cycle = 1'b1;
          next_r.write = wr_act;
          next_r.wdata = vme_data_i;
          next_r.state = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (r.addr[bridge_pkg::ADDR_GA_HI:bridge_pkg::ADDR_GA_LO] != ga_i) begin
          next_r.state = ST_SKIP; // slot bits compare, upper bits ignored
        end else begin
          case (decode(off))
            RG_LOCAL: begin
              next_r.strobe = 1'b1;
              next_r.lwrite = r.write;
              next_r.laddr = off;
              next_r.local_rdwr_bus_oe = r.write;
              next_r.state = ST_LOCAL;
            end
            RG_OWN: begin
              next_r.rdata = 32'h00000000;
              if (r.write) begin
                if (off == bridge_pkg::OFF_CTRL) begin
                  // action bits are not stored; they read back as the busy state of their action
                  if (r.wdata[bridge_pkg::CTRL_CFG_MAIN] || r.wdata[bridge_pkg::CTRL_CFG_DIAG]) begin
                    next_r.cfg_busy = 1'b1;
                    next_r.cfg_image = r.wdata[bridge_pkg::CTRL_CFG_DIAG] &&
                                       !r.wdata[bridge_pkg::CTRL_CFG_MAIN];
                    next_r.prog_cnt = bridge_pkg::PROG_CYC;
                  end
                  if (r.wdata[bridge_pkg::CTRL_RST_MAIN]) begin
                    next_r.main_rst_cnt = bridge_pkg::RST_CYC;
                  end
                  if (r.wdata[bridge_pkg::CTRL_RST_FLASH]) begin
                    next_r.flash_rst_cnt = bridge_pkg::RST_CYC;
                  end
                  next_r.override = r.wdata[bridge_pkg::CTRL_OVERRIDE];
                end else if (off == bridge_pkg::OFF_FLASH_ADDR) begin
                  next_r.faddr = r.wdata[bridge_pkg::FLASH_ADDR_W-1:0];
                end
              end else if (off == bridge_pkg::OFF_CTRL) begin
                // busy actions read as one until finished
                next_r.rdata[bridge_pkg::CTRL_OVERRIDE] = r.override;
                next_r.rdata[bridge_pkg::CTRL_RST_FLASH] = !r.flash_rst_n;
                next_r.rdata[bridge_pkg::CTRL_RST_MAIN] = r.main_rst;
                next_r.rdata[bridge_pkg::CTRL_CFG_DIAG] = r.cfg_busy && r.cfg_image;
                next_r.rdata[bridge_pkg::CTRL_CFG_MAIN] = r.cfg_busy && !r.cfg_image;
              end else if (off == bridge_pkg::OFF_FLASH_ADDR) begin
                next_r.rdata = {8'h00, r.faddr};
              end
              next_r.state = ST_ACK;
            end
            RG_FLASH: begin
              next_r.fcmd = (off == bridge_pkg::OFF_FLASH_CMD);
              next_r.fauto = (off == bridge_pkg::OFF_FLASH_AUTO);
              next_r.fhalf = 1'b0;
              next_r.rdata = 32'h00000000;
              if (off == bridge_pkg::OFF_FLASH_CMD && !r.write) begin
                next_r.state = ST_ACK; // command port is write only, reads zero
              end else begin
                // low half first; block reads run here too
                next_r.fpin_addr = r.faddr;
                next_r.fdata_out = r.wdata[15:0];
                next_r.fdata_oe = r.write;
                next_r.fce_n = 1'b0;
                next_r.foe_n = r.write;
                next_r.fwe_n = !r.write;
                next_r.fcnt = bridge_pkg::FLASH_ACC_CYC - 8'h01;
                next_r.state = ST_FLASH;
              end
            end
            default: begin
              next_r.rdata = 32'h00000000;
              next_r.state = ST_ACK;
            end
          endcase
        end
      end
      ST_LOCAL: begin
        // strobe held until the main fpga answers
        if (link.local_ack) begin
          next_r.strobe = 1'b0;
          next_r.local_rdwr_bus_oe = 1'b0;
          next_r.rdata = link.local_rdwr_bus;
          next_r.state = ST_ACK;
        end
      end
      ST_FLASH: begin
        if (r.fce_n) begin
          // one idle cycle between halves gives the strobes an edge
          next_r.fpin_addr = r.faddr + bridge_pkg::FLASH_HALF_STEP;
          next_r.fdata_out = r.wdata[31:16];
          next_r.fdata_oe = r.write;
          next_r.fce_n = 1'b0;
          next_r.foe_n = r.write;
          next_r.fwe_n = !r.write;
          next_r.fcnt = bridge_pkg::FLASH_ACC_CYC - 8'h01;
        end else if (r.fcnt != 8'h00) begin
          next_r.fcnt = r.fcnt - 8'h01;
        end else begin
          next_r.fce_n = 1'b1;
          next_r.foe_n = 1'b1;
          next_r.fwe_n = 1'b1;
          next_r.fdata_oe = 1'b0;
          if (r.fhalf) begin
            next_r.rdata[31:16] = flash_data_i;
          end else begin
            next_r.rdata[15:0] = flash_data_i;
          end
          if (r.fcmd || r.fhalf) begin
            if (r.fauto) begin
              next_r.faddr = r.faddr + bridge_pkg::FLASH_AUTO_STEP;
            end
            next_r.state = ST_ACK;
          end else begin
            next_r.fhalf = 1'b1;
          end
        end
      end
      ST_ACK: begin
        // dtack raised only now that every leg of the cycle is done
        next_r.dtack = 1'b1;
        next_r.data_oe = !r.write;
        if (!ds_act) begin
          next_r.dtack = 1'b0;
          next_r.data_oe = 1'b0;
          if (r.block) begin
            next_r.addr = r.addr + bridge_pkg::BLOCK_STEP;
          end
          next_r.state = ST_IDLE;
        end
      end
      ST_SKIP: begin
        // foreign cycle: no strobe, no dtack, just wait it out
        if (!ds_act) begin
          next_r.state = ST_IDLE;
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase

    // registered copies of the timer states so outputs come from flops
    next_r.main_rst = (next_r.main_rst_cnt != 8'h00);
    next_r.flash_rst_n = (next_r.flash_rst_cnt == 8'h00);
    next_r.prog_n = !(next_r.cfg_busy && next_r.prog_cnt != 8'h00);
    next_r.cfg_run = next_r.cfg_busy && next_r.prog_cnt == 8'h00 && !next_r.override;
  end

  // reset leaves a main reset and a configuration pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.state <= ST_IDLE;
      r.fce_n <= 1'b1;
      r.foe_n <= 1'b1;
      r.fwe_n <= 1'b1;
      r.override <= bridge_pkg::CTRL_OVERRIDE_RESET;
      r.cfg_busy <= 1'b1;
      r.prog_cnt <= bridge_pkg::PROG_CYC;
      r.prog_n <= 1'b0;
      r.main_rst_cnt <= bridge_pkg::RST_CYC;
      r.main_rst <= 1'b1;
      r.flash_rst_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign vme_data_o = r.rdata;
  assign vme_data_oe_o = r.data_oe;
  assign vme_dtack_n_o = !r.dtack;
  assign vme_dtack_oe_o = r.dtack;
  assign link.local_strobe = r.strobe;
  assign link.local_write = r.lwrite;
  assign link.local_addr = r.laddr;
  assign link.bridge_data = r.wdata;
  assign link.bridge_data_oe = r.local_rdwr_bus_oe;
  assign link.local_reset = r.main_rst;
  assign flash_addr_o = r.fpin_addr;
  assign flash_data_o = r.fdata_out;
  assign flash_data_oe_o = r.fdata_oe;
  assign flash_ce_n_o = r.fce_n;
  assign flash_oe_n_o = r.foe_n;
  assign flash_we_n_o = r.fwe_n;
  assign flash_rst_n_o = r.flash_rst_n;
  assign main_prog_n_o = r.prog_n;
  assign cfg_run_o = r.cfg_run;
  assign cfg_image_o = r.cfg_image;
endmodule

// *** verilog/vme_sync.sv ***
`timescale 1ns/1ns
module vme_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sync_s;

  sync_s r;
  sync_s next_r;

  // idle level of vme strobes is high, so reset to all ones
  always_comb begin
    next_r = r;
    next_r.stage1 = async_i;
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '1;
    end else begin
      r <= next_r;
    end
  end

  assign sync_o = r.stage2;
endmodule
